// File: hw/ocm_top.sv
// Behaviour
// [RULE1] cascaded edge PWM, both values low: pin high
// [RULE2] edge mode, init high, external clock: skip pulse
// [RULE3] PWM with prescaled timer skips first pulse
// [RULE4] codes 001, 010, 100 are one-shot
// [RULE5] prescaled one-shot: flag before pin change
// [RULE6] clearing mode drops a pending pin change
// [RULE7] software keeps prescaler 1:1 in PWM
// [RULE8] software waits twice prescale before clearing mode
// [RULE9] 1:1 prescale: pin and flag same cycle
`include "ocm_map.svh"

module ocm_top (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // register port
  input wire logic [`OCM_ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // alternate timer clock pin
  input wire logic EXT_CLK,
  // compare output and interrupt
  output logic COMPARE_OUTPUT_PIN,
  output logic IRQ
);

  ocm_pkg::ocm_bus_t bus;
  ocm_pkg::ocm_ctrl_t ctrl_reg;
  ocm_pkg::ocm_ctrl_t wctrl;
  ocm_pkg::ocm_state_t st_reg;
  ocm_pkg::ocm_state_t st_next;
  ocm_pkg::ocm_tmr_t tmr;
  logic [31:0] compare_primary_value_reg;
  logic [31:0] compare_secondary_value_reg;
  logic [`OCM_EV_W-1:0] stat_reg;
  logic [`OCM_EV_W-1:0] en_reg;
  logic [`OCM_EV_W-1:0] ev;
  logic [31:0] rdata_reg;
  logic [31:0] mask;
  logic [31:0] period;
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic ext_s3_reg;
  logic src_tick;
  logic pin_reg;
  logic pin_next;
  logic irq_reg;
  logic skip_reg;
  logic pend_reg;
  logic pend_val_reg;
  logic pend_last_reg;
  logic ctrl_wr;
  logic is_pwm;
  logic is_oneshot;
  logic pri_match;
  logic sec_match;
  logic casc_hold;
  logic one_act;
  logic one_val;
  logic one_last;
  logic presc_on;
  logic enter_run;

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
  assign wctrl = ocm_pkg::ocm_ctrl_t'(bus.wdata[`OCM_CTRL_W-1:0]);
  assign ctrl_wr = bus.wr && (bus.addr == `OCM_REG_CTRL);

  ////////////////////////////////////////////////////////////////////////
  // external clock pin: two-stage synchroniser, then edge detect
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg <= EXT_CLK;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  // peripheral clock ticks every cycle; the pin only on its rising edges
  assign src_tick = ctrl_reg.clk_ext ? (ext_s2_reg && !ext_s3_reg) : 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // mode decode and time base
  assign is_pwm = (ctrl_reg.mode == ocm_pkg::OCM_MODE_PWM_EDGE) ||
                  (ctrl_reg.mode == ocm_pkg::OCM_MODE_PWM_EDGE_ALT);
  // [RULE4] one-shot codes
  assign is_oneshot = (ctrl_reg.mode == ocm_pkg::OCM_MODE_ONE_HIGH) ||
                      (ctrl_reg.mode == ocm_pkg::OCM_MODE_ONE_LOW) ||
                      (ctrl_reg.mode == ocm_pkg::OCM_MODE_ONE_PULSE);
  assign presc_on = (ctrl_reg.prescale != `OCM_PRESCALE_1);
  assign mask = ctrl_reg.cascade ? `OCM_MASK_32 : `OCM_MASK_16;
  assign period = is_pwm ? compare_secondary_value_reg : `OCM_MASK_32;

  ocm_timebase u_timebase (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .run(ctrl_reg.tmr_on),
    .src_tick(src_tick),
    .prescale(ctrl_reg.prescale),
    .period(period),
    .mask(mask),
    .tmr(tmr)
  );

  assign pri_match = tmr.tick && ((tmr.count & mask) == (compare_primary_value_reg & mask));
  assign sec_match = tmr.tick && ((tmr.count & mask) == (compare_secondary_value_reg & mask));
  // [RULE1] cascaded threshold
  assign casc_hold = is_pwm && ctrl_reg.cascade &&
                     (compare_primary_value_reg < `OCM_CASC_LIMIT) &&
                     (compare_secondary_value_reg < `OCM_CASC_LIMIT);

  ////////////////////////////////////////////////////////////////////////
  // control state
  always_comb begin
    case (st_reg)
      ocm_pkg::OCM_ST_IDLE: st_next = (ctrl_reg.mode != ocm_pkg::OCM_MODE_OFF) ?
                                      ocm_pkg::OCM_ST_RUN : ocm_pkg::OCM_ST_IDLE;
      ocm_pkg::OCM_ST_RUN: st_next = (one_act && one_last && !presc_on) ||
                                     (pend_reg && pend_last_reg && tmr.tick) ?
                                     ocm_pkg::OCM_ST_DONE : ocm_pkg::OCM_ST_RUN;
      ocm_pkg::OCM_ST_DONE: st_next = ocm_pkg::OCM_ST_DONE;
      default: st_next = ocm_pkg::OCM_ST_IDLE;
    endcase
    if (ctrl_reg.mode == ocm_pkg::OCM_MODE_OFF) begin
      st_next = ocm_pkg::OCM_ST_IDLE;
    end
  end

  assign enter_run = (st_reg == ocm_pkg::OCM_ST_IDLE) && (st_next == ocm_pkg::OCM_ST_RUN);

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_reg <= ocm_pkg::OCM_ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ctrl_reg <= `OCM_CTRL_RESET;
      compare_primary_value_reg <= '0;
      compare_secondary_value_reg <= '0;
      en_reg <= '0;
    end else if (bus.wr) begin
      if (ctrl_wr) ctrl_reg <= wctrl;
      if (bus.addr == `OCM_REG_PRIMARY) compare_primary_value_reg <= bus.wdata;
      if (bus.addr == `OCM_REG_SECONDARY) compare_secondary_value_reg <= bus.wdata;
      if (bus.addr == `OCM_REG_ENABLE) en_reg <= bus.wdata[`OCM_EV_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one-shot action: the flag sets on the primary match itself, not on the secondary one
  always_comb begin
    one_act = 1'b0;
    one_val = 1'b0;
    one_last = 1'b1;
    if (st_reg == ocm_pkg::OCM_ST_RUN && !pend_reg) begin
      case (ctrl_reg.mode)
        ocm_pkg::OCM_MODE_ONE_HIGH: begin
          one_act = pri_match;
          one_val = 1'b1;
        end
        ocm_pkg::OCM_MODE_ONE_LOW: begin
          one_act = pri_match;
        end
        ocm_pkg::OCM_MODE_ONE_PULSE: begin
          one_act = pin_reg ? sec_match : pri_match;
          one_val = !pin_reg;
          one_last = pin_reg;
        end
        default: one_act = 1'b0;
      endcase
    end
  end

  // a prescaled one-shot holds the pin change until the next timer tick
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pend_reg <= 1'b0;
      pend_val_reg <= 1'b0;
      pend_last_reg <= 1'b0;
    end else if (ctrl_wr && wctrl.mode == ocm_pkg::OCM_MODE_OFF) begin
      // [RULE6] pending change lost
      pend_reg <= 1'b0;
    end else if (one_act && presc_on) begin
      // [RULE5] pin change deferred
      pend_reg <= 1'b1;
      pend_val_reg <= one_val;
      pend_last_reg <= one_last;
    end else if (tmr.tick) begin
      pend_reg <= 1'b0;
    end
  end

  // first-pulse suppression, cleared by the first period wrap
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      skip_reg <= 1'b0;
    end else if (enter_run && is_pwm) begin
      // [RULE2] [RULE3] first pulse missing
      skip_reg <= presc_on ||
                  (ctrl_reg.pin_init && compare_primary_value_reg != '0 && ctrl_reg.clk_ext);
    end else if (tmr.wrap || st_reg == ocm_pkg::OCM_ST_IDLE) begin
      skip_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output pin
  always_comb begin
    pin_next = pin_reg;
    if (enter_run) begin
      pin_next = ctrl_reg.pin_init;
    end else if (st_reg == ocm_pkg::OCM_ST_RUN) begin
      case (ctrl_reg.mode)
        ocm_pkg::OCM_MODE_TOGGLE: if (pri_match) pin_next = !pin_reg;
        ocm_pkg::OCM_MODE_CONT_PULSE: begin
          if (pri_match) pin_next = 1'b1;
          if (sec_match) pin_next = 1'b0;
        end
        ocm_pkg::OCM_MODE_PWM_EDGE, ocm_pkg::OCM_MODE_PWM_EDGE_ALT: begin
          if (tmr.wrap) pin_next = !skip_reg;
          if (pri_match) pin_next = 1'b0;
          // [RULE1] pin held high
          if (casc_hold) pin_next = 1'b1;
        end
        default: begin
          // [RULE9] same-cycle pin change
          if (one_act && !presc_on) pin_next = one_val;
          if (pend_reg && tmr.tick) pin_next = pend_val_reg;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pin_reg <= 1'b0;
    end else begin
      pin_reg <= pin_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky events, set wins over clear
  assign ev[`OCM_EV_MATCH] = (st_reg == ocm_pkg::OCM_ST_RUN) && pri_match;
  assign ev[`OCM_EV_PIN] = (pin_next != pin_reg) && !enter_run;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      stat_reg <= '0;
    end else if (bus.wr && bus.addr == `OCM_REG_CLEAR) begin
      stat_reg <= (stat_reg & ~bus.wdata[`OCM_EV_W-1:0]) | ev;
    end else begin
      stat_reg <= stat_reg | ev;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(stat_reg & en_reg);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rdata_reg <= '0;
    end else if (bus.rd) begin
      case (bus.addr)
        `OCM_REG_CTRL: rdata_reg <= {23'h000000, ctrl_reg};
        `OCM_REG_PRIMARY: rdata_reg <= compare_primary_value_reg;
        `OCM_REG_SECONDARY: rdata_reg <= compare_secondary_value_reg;
        `OCM_REG_STATUS: rdata_reg <= {29'h00000000, pin_reg, stat_reg};
        `OCM_REG_ENABLE: rdata_reg <= {30'h00000000, en_reg};
        `OCM_REG_TIMER: rdata_reg <= tmr.count;
        default: rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  assign RDATA = rdata_reg;
  assign COMPARE_OUTPUT_PIN = pin_reg;
  assign IRQ = irq_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  AST_CASC_HIGH: assert property ( // [RULE1]
    (st_reg == ocm_pkg::OCM_ST_RUN) && casc_hold && !ctrl_wr |=> COMPARE_OUTPUT_PIN)
    else $error("cascaded low values did not hold the pin high");
  AST_EDGE_SKIP: assert property ( // [RULE2]
    enter_run && is_pwm && ctrl_reg.pin_init && ctrl_reg.clk_ext &&
    compare_primary_value_reg != '0 |=> skip_reg)
    else $error("edge mode with external clock did not skip first pulse");
  AST_PRESC_SKIP: assert property ( // [RULE3]
    skip_reg && tmr.wrap && !casc_hold && !enter_run |=> !$rose(pin_reg))
    else $error("first pwm pulse appeared with prescaled timer");
  AST_DONE_ONESHOT: assert property ( // [RULE4]
    st_reg == ocm_pkg::OCM_ST_DONE && ctrl_reg.mode != ocm_pkg::OCM_MODE_OFF |-> is_oneshot)
    else $error("done state outside a one-shot mode");
  AST_DONE_STAYS: assert property ( // [RULE4]
    st_reg == ocm_pkg::OCM_ST_DONE && ctrl_reg.mode != ocm_pkg::OCM_MODE_OFF && !ctrl_wr
    |=> st_reg == ocm_pkg::OCM_ST_DONE && $stable(pin_reg))
    else $error("one-shot acted more than once");
  AST_FLAG_EARLY: assert property ( // [RULE5]
    one_act && presc_on && !ctrl_wr |=> stat_reg[`OCM_EV_MATCH] && pend_reg && $stable(pin_reg))
    else $error("prescaled one-shot did not defer the pin change");
  AST_CLEAR_DROP: assert property ( // [RULE6]
    ctrl_wr && wctrl.mode == ocm_pkg::OCM_MODE_OFF |=> !pend_reg ##1 $stable(pin_reg))
    else $error("pending pin change survived mode clear");
  AST_SAME_CYCLE: assert property ( // [RULE9]
    one_act && !presc_on && ctrl_reg.mode == ocm_pkg::OCM_MODE_ONE_HIGH
    |=> COMPARE_OUTPUT_PIN && stat_reg[`OCM_EV_MATCH])
    else $error("1:1 one-shot pin and flag not in same cycle");

  COV_ONESHOT_PRESC: cover property (one_act && presc_on ##[1:300] st_reg == ocm_pkg::OCM_ST_DONE);
  COV_PWM_SKIP: cover property (skip_reg ##1 tmr.wrap ##[1:1000] $rose(pin_reg));
  COV_IRQ: cover property ($rose(IRQ));

endmodule // ocm_top

// File: hw/ocm_map.svh
`ifndef OCM_MAP_SVH
`define OCM_MAP_SVH

// register indices on the plain register port
`define OCM_ADDR_W 4
`define OCM_REG_CTRL 4'h0
`define OCM_REG_PRIMARY 4'h1
`define OCM_REG_SECONDARY 4'h2
`define OCM_REG_STATUS 4'h3
`define OCM_REG_CLEAR 4'h4
`define OCM_REG_ENABLE 4'h5
`define OCM_REG_TIMER 4'h6

// control field layout and reset
`define OCM_CTRL_W 9
`define OCM_CTRL_RESET 9'h000

// event bits of status, clear and enable
`define OCM_EV_W 2
`define OCM_EV_MATCH 0
`define OCM_EV_PIN 1

// compare widths and cascaded-mode threshold
`define OCM_MASK_16 32'h0000FFFF
`define OCM_MASK_32 32'hFFFFFFFF
`define OCM_CASC_LIMIT 32'h0000FFFF

// prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
`define OCM_PRE_W 8
`define OCM_PRE_END_1 8'h00
`define OCM_PRE_END_8 8'h07
`define OCM_PRE_END_64 8'h3F
`define OCM_PRE_END_256 8'hFF
`define OCM_PRESCALE_1 2'h0

`endif

// File: hw/ocm_pkg.sv
package ocm_pkg;

  typedef enum logic [2:0] {
    OCM_MODE_OFF = 3'h0,
    OCM_MODE_ONE_HIGH = 3'h1,
    OCM_MODE_ONE_LOW = 3'h2,
    OCM_MODE_TOGGLE = 3'h3,
    OCM_MODE_ONE_PULSE = 3'h4,
    OCM_MODE_CONT_PULSE = 3'h5,
    OCM_MODE_PWM_EDGE = 3'h6,
    OCM_MODE_PWM_EDGE_ALT = 3'h7
  } ocm_mode_t;

  typedef enum logic [2:0] {
    OCM_ST_IDLE = 3'b001,
    OCM_ST_RUN = 3'b010,
    OCM_ST_DONE = 3'b100
  } ocm_state_t;

  // bit 8 down to bit 0 of the control register
  typedef struct packed {
    logic tmr_on;
    logic pin_init;
    logic clk_ext;
    logic cascade;
    logic [1:0] prescale;
    ocm_mode_t mode;
  } ocm_ctrl_t;

  typedef struct packed {
    logic [31:0] count;
    logic tick;
    logic wrap;
  } ocm_tmr_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ocm_bus_t;

endpackage

// File: hw/ocm_timebase.sv
`include "ocm_map.svh"

module ocm_timebase (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic src_tick,
  input wire logic [1:0] prescale,
  input wire logic [31:0] period,
  input wire logic [31:0] mask,
  // timer state
  output ocm_pkg::ocm_tmr_t tmr
);

  logic [`OCM_PRE_W-1:0] pre_reg;
  logic [`OCM_PRE_W-1:0] pre_end;
  logic [31:0] count_reg;
  logic tick;

  always_comb begin
    case (prescale)
      2'h0: pre_end = `OCM_PRE_END_1;
      2'h1: pre_end = `OCM_PRE_END_8;
      2'h2: pre_end = `OCM_PRE_END_64;
      default: pre_end = `OCM_PRE_END_256;
    endcase
  end

  assign tick = run && src_tick && (pre_reg == pre_end);

  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      pre_reg <= '0;
    end else if (src_tick) begin
      pre_reg <= (pre_reg == pre_end) ? '0 : pre_reg + 8'h01;
    end
  end

  // count wraps at the period, or at the width limit in all non-PWM modes
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      count_reg <= '0;
    end else if (tick) begin
      count_reg <= ((count_reg & mask) >= (period & mask)) ? '0 : (count_reg + 32'h1) & mask;
    end
  end

  assign tmr.count = count_reg;
  assign tmr.tick = tick;
  assign tmr.wrap = tick && ((count_reg & mask) >= (period & mask));

endmodule // ocm_timebase

// File: tb/ocm_top_tb.sv
`include "ocm_map.svh"

module ocm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk;
  logic rst_n;
  logic [`OCM_ADDR_W-1:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic ext_clk;
  logic pin;
  logic irq;
  int errors;
  int n_compared;
  int cycles;
  int r;
  logic [31:0] q;
  ocm_pkg::ocm_mode_t os_mode [3] = '{ocm_pkg::OCM_MODE_ONE_HIGH, ocm_pkg::OCM_MODE_ONE_LOW,
                                      ocm_pkg::OCM_MODE_ONE_PULSE};
  logic os_init [3] = '{1'h0, 1'h1, 1'h0};
  int pdiv [3] = '{8, 64, 256};

  ocm_top dut_u (
    .SYS_CLK(sys_clk),
    .RST_N(rst_n),
    .ADDR(addr),
    .WDATA(wdata),
    .WR(wr),
    .RD(rd),
    .RDATA(rdata),
    .EXT_CLK(ext_clk),
    .COMPARE_OUTPUT_PIN(pin),
    .IRQ(irq)
  );

  ////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end

  // alternate clock runs free at a quarter of the system rate
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    ext_clk <= cycles[1];
    if (cycles == 12000) begin
      errors = errors + 1;
      $display("unexpected at %0t: timeout", $time);
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s finished, mismatches so far %0d", name, errors);
  endtask

  task automatic reg_write(input logic [`OCM_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge sys_clk);
    wr <= 1'h0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [`OCM_ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge sys_clk);
    rd <= 1'h0;
    #1;
    d = rdata;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // r becomes 1 once the watched output leaves lvl within n cycles
  task automatic wait_sig(input logic use_irq, input logic lvl, input int n);
    r = 0;
    for (int i = 0; i < n && r == 0; i++) begin
      idle(1);
      if ((use_irq ? irq : pin) !== lvl) r = 1;
    end
  endtask

  task automatic count_rises(input int n);
    logic prev;
    prev = pin;
    r = 0;
    repeat (n) begin
      idle(1);
      if (pin === 1'h1 && prev !== 1'h1) r++;
      prev = pin;
    end
  endtask

  function automatic logic [31:0] mk(input logic init, input logic ext, input logic casc,
                                     input logic [1:0] pre, input logic [2:0] mode);
    return {23'h0, 1'h1, init, ext, casc, pre, mode};
  endfunction

  // timer stopped and events cleared first, so no stale match leaks in
  task automatic setup(input logic [31:0] p, input logic [31:0] s, input logic [31:0] c);
    reg_write(`OCM_REG_CTRL, 32'h0);
    reg_write(`OCM_REG_CLEAR, 32'h3);
    reg_write(`OCM_REG_PRIMARY, p);
    reg_write(`OCM_REG_SECONDARY, s);
    reg_write(`OCM_REG_CTRL, c);
    idle(2);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'h0;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'h0;
    rd = 1'h0;
    ext_clk = 1'h0;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'h1;

    for (int a = 0; a < 8; a++) begin
      reg_read(a[3:0], q);
      check_word(q, 32'h0, "reset value");
    end
    reg_write(`OCM_REG_ENABLE, 32'hFFFFFFFF);
    reg_read(`OCM_REG_ENABLE, q);
    check_word(q, 32'h3, "enable width");
    reg_write(`OCM_REG_STATUS, 32'h7);
    reg_read(`OCM_REG_STATUS, q);
    check_word(q, 32'h0, "status is read-only");
    reg_write(4'hF, 32'hFFFFFFFF);
    reg_read(4'hF, q);
    check_word(q, 32'h0, "unmapped index");
    reg_write(`OCM_REG_ENABLE, 32'h1);
    end_test("registers");

    foreach (os_mode[i]) begin
      setup(32'h3, 32'h6, mk(os_init[i], 1'h0, 1'h0, 2'h0, os_mode[i]));
      check_bit(pin, os_init[i], "start level");
      wait_sig(1'h0, os_init[i], 8);
      check_bit(r[0], 1'h1, "one-shot change");
      check_bit(irq, 1'h0, "flag lags pin");
      idle(1);
      check_bit(irq, 1'h1, "flag with pin");
      if (i == 2) begin
        wait_sig(1'h0, 1'h1, 8);
        check_bit(r[0], 1'h1, "pulse end");
      end
      wait_sig(1'h0, pin, 30);
      check_bit(r[0], 1'h0, "pin frozen after one shot");
    end
    end_test("one-shot");

    reg_read(`OCM_REG_STATUS, q);
    check_word(q, 32'h3, "status after pulse");
    reg_write(`OCM_REG_ENABLE, 32'h0);
    idle(2);
    check_bit(irq, 1'h0, "masked");
    reg_write(`OCM_REG_ENABLE, 32'h1);
    idle(2);
    check_bit(irq, 1'h1, "unmasked");
    reg_write(`OCM_REG_CLEAR, 32'h1);
    idle(2);
    check_bit(irq, 1'h0, "cleared");
    reg_read(`OCM_REG_STATUS, q);
    check_word(q, 32'h2, "clear one bit");
    end_test("interrupt");

    // second pass clears the mode too early on purpose
    for (int k = 0; k < 2; k++) begin
      setup(32'h3, 32'h6, mk(1'h0, 1'h0, 1'h0, 2'h1, ocm_pkg::OCM_MODE_ONE_HIGH));
      wait_sig(1'h1, 1'h0, 60);
      check_bit(pin, 1'h0, "flag before pin change");
      if (k == 1) reg_write(`OCM_REG_CTRL, mk(1'h0, 1'h0, 1'h0, 2'h1, 3'h0));
      wait_sig(1'h0, 1'h0, 20);
      check_bit(r[0], k == 0, "late pin change");
    end
    end_test("prescaled one-shot");

    // toggle and continuous pulse keep running past the first match
    setup(32'h3, 32'h6, mk(1'h1, 1'h0, 1'h0, 2'h0, ocm_pkg::OCM_MODE_TOGGLE));
    wait_sig(1'h0, 1'h1, 8);
    check_bit(r[0], 1'h1, "toggle on match");
    setup(32'h3, 32'h6, mk(1'h0, 1'h0, 1'h0, 2'h0, ocm_pkg::OCM_MODE_CONT_PULSE));
    wait_sig(1'h0, 1'h0, 8);
    check_bit(r[0], 1'h1, "continuous pulse start");
    wait_sig(1'h0, 1'h1, 8);
    check_bit(r[0], 1'h1, "continuous pulse end");
    end_test("repeating modes");

    setup(32'h2, 32'h5, mk(1'h0, 1'h0, 1'h1, 2'h0, ocm_pkg::OCM_MODE_PWM_EDGE));
    check_bit(pin, 1'h1, "cascade pin high");
    count_rises(40);
    check_word(r, 0, "cascade pulses");
    check_bit(pin, 1'h1, "cascade pin stays high");
    reg_read(`OCM_REG_STATUS, q);
    check_word(q, 32'h7, "live pin in status");
    end_test("cascade");

    // window ends before the earliest second wrap of the external clock
    for (int k = 0; k < 2; k++) begin
      setup(32'h1, 32'h2, mk(k[0], 1'h1, 1'h0, 2'h0, ocm_pkg::OCM_MODE_PWM_EDGE));
      count_rises(16);
      check_bit(r > 0, k == 0, "first pulse on external clock");
    end
    end_test("external clock");

    setup(32'h3, 32'h7, mk(1'h0, 1'h0, 1'h0, 2'h0, ocm_pkg::OCM_MODE_PWM_EDGE));
    count_rises(20);
    check_bit(r > 0, 1'h1, "first pulse at 1:1");
    // first window spans the first wrap, second one the second wrap
    foreach (pdiv[i]) begin
      setup(32'h3, 32'h7, mk(1'h0, 1'h0, 1'h0, 2'(i + 1), ocm_pkg::OCM_MODE_PWM_EDGE_ALT));
      count_rises(8 * pdiv[i] + 16);
      check_word(r, 0, "first pulse missing");
      count_rises(8 * pdiv[i]);
      check_bit(r > 0, 1'h1, "second pulse");
    end
    end_test("pwm");
    summarize();
  end
endmodule // ocm_top_tb
